// *** pwr_seq_consts.vh ***
// Purpose: constants for the power-on reset and power-down sequencer
// Assumes: 100 MHz clock, supply comparators delivered as levels
// Notes: time figures in their own unit, cycle counts derived from them
`ifndef PWR_SEQ_CONSTS_VH
`define PWR_SEQ_CONSTS_VH
`define CLK_PERIOD_NS 10
`define POR_DELAY_MS 128
// 128 ms at 10 ns per cycle, sized to the counter width
`define POR_DELAY_CYCLES 24'hC35000
`define POR_CNT_W 24
`define PDN_REQ_BIT 1
`define PORT_W 32
`define WAKE_W 4
`define ST_RUN 2'h0
`define ST_PDN 2'h1
`define ST_EXIT 2'h2
`define ST_RESET 2'h3
`endif

// *** por_timer.v ***
// Purpose: power-on reset hold and release delay
// Assumes: supply_ok and supply_dead are comparator levels, synchronous
// Notes: delay is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "pwr_seq_consts.vh"
module por_timer #(
    parameter [`POR_CNT_W-1:0] DELAY_CYCLES = `POR_DELAY_CYCLES
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire supply_ok,
    input wire supply_dead,
    output reg por_active_q
);
    reg [`POR_CNT_W-1:0] cnt_q;

    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= {`POR_CNT_W{1'b0}};
            por_active_q <= 1'b1;
        end else if (clk_en) begin
            if (!supply_ok) begin
                // hold while supply_ok is low
                // reset asserts on threshold loss and stays asserted all
                // the way down; supply_dead only marks the bottom of it
                cnt_q <= {`POR_CNT_W{1'b0}};
                por_active_q <= 1'b1;
            end else if (por_active_q) begin
                if (cnt_q >= DELAY_CYCLES - 1'b1) begin
                    por_active_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule

// *** pin_hold.v ***
// Purpose: freeze of port pins during power-down; strobes are forced low in pwr_seq
// Assumes: hold_en is a level from the sequencer
// Notes: latched values are captured at the last edge before hold rises
`timescale 1ns/1ps
`include "pwr_seq_consts.vh"
module pin_hold #(
    parameter W = `PORT_W
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire hold_en,
    input wire [W-1:0] port_in,
    output reg [W-1:0] port_q
);
    always @(posedge clk) begin
        if (!reset_n) begin
            port_q <= {W{1'b0}};
        end else if (clk_en) begin
            if (!hold_en)
                port_q <= port_in;
        end
    end
endmodule

// *** pwr_seq.v ***
// Purpose: power-on reset and power-down sequencer of a small controller
// Assumes: comparators and core requests synchronous to clk
// Notes: the reset-pin exit and a supply loss both reset the core; wake inputs resume it
`timescale 1ns/1ps
`include "pwr_seq_consts.vh"
module pwr_seq #(
    parameter [`POR_CNT_W-1:0] DELAY_CYCLES = `POR_DELAY_CYCLES,
    parameter PORT_W = `PORT_W,
    parameter WAKE_W = `WAKE_W
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire supply_ok,
    input wire supply_dead,
    input wire reset_pin,
    input wire [7:0] power_control_register,
    input wire oscillator_halt_bit,
    input wire time_interval_counter_req,
    input wire [WAKE_W-1:0] wake_req,
    input wire [PORT_W-1:0] port_drive,
    input wire dac_drive_en,
    input wire ale_in,
    input wire program_store_strobe_in,
    output reg chip_reset_q,
    output reg pll_enable_q,
    output reg core_clk_enable_q,
    output reg osc_enable_q,
    output reg time_interval_counter_en_q,
    output reg periph_enable_q,
    output reg [PORT_W-1:0] port_out_q,
    output reg dac_oe_q,
    output reg ale_q,
    output reg program_store_strobe_q,
    output reg powerdown_q
);
    localparam [1:0] ST_RUN = `ST_RUN;
    localparam [1:0] ST_PDN = `ST_PDN;
    localparam [1:0] ST_EXIT = `ST_EXIT;
    localparam [1:0] ST_RESET = `ST_RESET;

    wire por_active;
    wire [PORT_W-1:0] port_held;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg pdn_req_prev_q;
    wire pdn_req;
    wire pdn_rise;
    wire any_wake;

    por_timer #(
        .DELAY_CYCLES(DELAY_CYCLES)
    ) u_por (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .supply_ok(supply_ok),
        .supply_dead(supply_dead),
        .por_active_q(por_active)
    );

    pin_hold #(
        .W(PORT_W)
    ) u_hold (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .hold_en(state_d == ST_PDN),
        .port_in(port_drive),
        .port_q(port_held)
    );

    assign pdn_req = power_control_register[`PDN_REQ_BIT];
    // edge so a bit left set after wake does not re-enter at once
    assign pdn_rise = pdn_req & ~pdn_req_prev_q;
    assign any_wake = |wake_req;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (pdn_rise)
                    state_d = ST_PDN;
            end
            ST_PDN: begin
                if (reset_pin)
                    state_d = ST_RESET;
                else if (any_wake)
                    state_d = ST_EXIT;
            end
            ST_EXIT: begin
                state_d = ST_RUN;
            end
            ST_RESET: begin
                if (!reset_pin)
                    state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        if (por_active)
            state_d = ST_RUN;
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_RUN;
            pdn_req_prev_q <= 1'b0;
            chip_reset_q <= 1'b1;
            pll_enable_q <= 1'b0;
            core_clk_enable_q <= 1'b0;
            osc_enable_q <= 1'b1;
            time_interval_counter_en_q <= 1'b0;
            periph_enable_q <= 1'b0;
            port_out_q <= {PORT_W{1'b0}};
            dac_oe_q <= 1'b0;
            ale_q <= 1'b0;
            program_store_strobe_q <= 1'b0;
            powerdown_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            pdn_req_prev_q <= pdn_req;
            chip_reset_q <= por_active | (state_d == ST_RESET) |
                            (state_q == ST_PDN && reset_pin);
            powerdown_q <= (state_d == ST_PDN);
            if (state_d == ST_PDN) begin
                pll_enable_q <= 1'b0;
                core_clk_enable_q <= 1'b0;
                osc_enable_q <= ~oscillator_halt_bit;
                time_interval_counter_en_q <= time_interval_counter_req &
                                              ~oscillator_halt_bit;
                periph_enable_q <= 1'b0;
                dac_oe_q <= 1'b0;
                ale_q <= 1'b0;
                program_store_strobe_q <= 1'b0;
            end else begin
                pll_enable_q <= ~por_active;
                core_clk_enable_q <= ~por_active;
                osc_enable_q <= 1'b1;
                time_interval_counter_en_q <= time_interval_counter_req &
                                              ~por_active;
                periph_enable_q <= ~por_active;
                dac_oe_q <= dac_drive_en & ~por_active;
                ale_q <= ale_in & ~por_active;
                program_store_strobe_q <= program_store_strobe_in &
                                          ~por_active;
            end
            port_out_q <= (state_d == ST_PDN) ? port_held : port_drive;
        end
    end
endmodule

// *** pwr_seq_assertions.sv ***
// Purpose: timing checks on the power sequencer ports
// Assumes: clk_en high whenever a check matters
// Notes: entry and exit may take one or two edges
`timescale 1ns/1ps
module pwr_seq_chk #(
    parameter [23:0] DELAY_CYCLES = 24'h000010
) (
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    input wire supply_ok,
    input wire reset_pin,
    input wire [7:0] power_control_register,
    input wire oscillator_halt_bit,
    input wire [3:0] wake_req,
    input wire [31:0] port_out_q,
    input wire chip_reset_q,
    input wire pll_enable_q,
    input wire core_clk_enable_q,
    input wire osc_enable_q,
    input wire time_interval_counter_en_q,
    input wire periph_enable_q,
    input wire dac_oe_q,
    input wire ale_q,
    input wire program_store_strobe_q,
    input wire powerdown_q
);
    localparam int HOLD = DELAY_CYCLES - 2;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_por_hold: assert property (
        !supply_ok && clk_en |-> ##2 chip_reset_q)
        else $error("no supply hold");
    a_por_delay: assert property (
        $rose(supply_ok) |-> ##HOLD chip_reset_q ##2 chip_reset_q
        ##1 !chip_reset_q)
        else $error("release delay wrong");
    a_pdn_entry: assert property (
        $rose(power_control_register[1]) && clk_en && !chip_reset_q &&
        !reset_pin && wake_req == 4'h0 |-> ##[1:2] powerdown_q)
        else $error("no power-down entry");
    a_clocks_off: assert property (
        powerdown_q |-> !pll_enable_q && !core_clk_enable_q)
        else $error("clocks run in power-down");
    a_osc_choice: assert property (
        powerdown_q && $stable(oscillator_halt_bit) |->
        osc_enable_q == !oscillator_halt_bit) else $error("osc wrong");
    a_periph_off: assert property (
        powerdown_q |-> !periph_enable_q &&
        (!time_interval_counter_en_q || osc_enable_q))
        else $error("peripheral on");
    a_port_hold: assert property (
        powerdown_q && $past(powerdown_q) |-> $stable(port_out_q))
        else $error("port moved");
    a_strobes_low: assert property (
        powerdown_q |-> !dac_oe_q && !ale_q && !program_store_strobe_q)
        else $error("strobe or dac active");
    a_wake_exit: assert property (
        powerdown_q && wake_req != 4'h0 && clk_en && !reset_pin &&
        supply_ok |-> ##[1:2] (!powerdown_q && pll_enable_q &&
        core_clk_enable_q)) else $error("wake failed");
    a_pin_exit: assert property (
        powerdown_q && reset_pin && clk_en |-> ##[1:2] chip_reset_q)
        else $error("pin exit failed");
    c_entry: cover property ($rose(powerdown_q));
    c_wake: cover property (powerdown_q && wake_req != 4'h0);
    c_pin: cover property (powerdown_q && reset_pin);
endmodule
bind pwr_seq pwr_seq_chk #(.DELAY_CYCLES(DELAY_CYCLES)) chk (.*);

// *** supply_pin_model.sv ***
// Purpose: digital supply rail and external reset pin
// Assumes: changes land on falling clock edges
// Notes: rail always passes 1 V before the release threshold
`timescale 1ns/1ps
module supply_pin_model (
    input wire clk,
    output reg supply_ok,
    output reg supply_dead,
    output reg reset_pin
);
    initial begin
        supply_ok = 1'b0;
        supply_dead = 1'b1;
        reset_pin = 1'b0;
    end
    task rise;
        @(negedge clk) supply_dead = 1'b0;
        @(negedge clk) supply_ok = 1'b1;
    endtask
    task fall;
        @(negedge clk) supply_ok = 1'b0;
        @(negedge clk) supply_dead = 1'b1;
    endtask
    task pin(input logic v);
        @(negedge clk) reset_pin = v;
    endtask
endmodule

// *** tb_top.sv ***
// Purpose: directed bench for the power sequencer
// Assumes: release delay shortened to 16 cycles
// Notes: inputs move on falling edges only
`timescale 1ns/1ps
module tb_top;
    logic clk, reset_n, clk_en, halt, icr, dac, ale, pss;
    logic s_ok, s_dead, rpin, chip_rst, pll, core, osc, icnt_en, per;
    logic dac_oe, ale_o, pss_o, pdn;
    logic [7:0] pcr;
    logic [3:0] wake;
    logic [31:0] pdrv, pout;
    integer n_errors = 0, n_checks = 0, i;
    supply_pin_model sup (.clk(clk), .supply_ok(s_ok),
        .supply_dead(s_dead), .reset_pin(rpin));
    pwr_seq #(.DELAY_CYCLES(24'h000010)) uut (.clk(clk),
        .reset_n(reset_n), .clk_en(clk_en), .supply_ok(s_ok),
        .supply_dead(s_dead), .reset_pin(rpin),
        .power_control_register(pcr), .oscillator_halt_bit(halt),
        .time_interval_counter_req(icr), .wake_req(wake),
        .port_drive(pdrv),
        .dac_drive_en(dac), .ale_in(ale), .program_store_strobe_in(pss),
        .chip_reset_q(chip_rst), .pll_enable_q(pll),
        .core_clk_enable_q(core), .osc_enable_q(osc),
        .time_interval_counter_en_q(icnt_en), .periph_enable_q(per),
        .port_out_q(pout), .dac_oe_q(dac_oe), .ale_q(ale_o),
        .program_store_strobe_q(pss_o), .powerdown_q(pdn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    // bounded wait for a power-down state change
    task wait_pd(input logic v);
        for (i = 0; i < 4 && pdn !== v; i++) tick(1);
        chk(pdn, v);
        if (pdn !== v) complete_run;
    endtask
    task s_por;
        sup.rise;
        tick(15);
        chk(chip_rst, 1'b1);
        tick(4);
        chk(chip_rst, 1'b0);
    endtask
    task s_pdn(input logic h);
        pdrv = 32'hA5C30F96;
        halt = h;
        pcr = 8'h00;
        tick(1);
        pcr = 8'h02;
        wait_pd(1'b1);
        chk({pll, core}, 2'h0);
        chk(osc, !h);
        chk({per, icnt_en}, {1'b0, !h});
        chk({dac_oe, ale_o, pss_o}, 3'h0);
        pdrv = 32'h5A3CF069;
        tick(3);
        chk(pout, 32'hA5C30F96);
    endtask
    // each wake source alone, both oscillator choices
    task s_wake;
        integer k;
        for (k = 0; k < 4; k++) begin
            s_pdn(k[0]);
            wake = 4'h1 << k;
            wait_pd(1'b0);
            chk({pll, core, chip_rst}, 3'h6);
            wake = 4'h0;
        end
    endtask
    task s_pin;
        s_pdn(1'b0);
        sup.pin(1'b1);
        tick(2);
        chk(chip_rst, 1'b1);
        tick(3);
        chk(chip_rst, 1'b1);
        sup.pin(1'b0);
        tick(2);
        chk({chip_rst, pdn}, 2'h0);
    endtask
    task s_drop;
        sup.fall;
        tick(1);
        chk(chip_rst, 1'b1);
        s_por;
    endtask
    initial begin
        {reset_n, halt, pcr, wake, pdrv} = 0;
        {clk_en, icr, dac, ale, pss} = 5'h1F;
        tick(2);
        reset_n = 1'b1;
        s_por;
        s_wake;
        s_pin;
        s_drop;
        complete_run;
    end
endmodule
